// >>> verilog/rung_pkg.sv
/*
 * rung_pkg: shared types and constants for the boolean rung evaluator.
 * assumes a single scan clock; instructions arrive as packed structs.
 */
package rung_pkg;

  localparam int STACK_DEPTH = 8;
  localparam int ADDR_W      = 12;
  localparam int WORD_W      = 16;
  localparam int BITSEL_W    = 4;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_LOAD_OPEN,
    OP_LOAD_CLOSED,
    OP_AND_OPEN,
    OP_AND_CLOSED,
    OP_OR_OPEN,
    OP_OR_CLOSED,
    OP_LOAD_WORD_BIT_OPEN,
    OP_LOAD_WORD_BIT_CLOSED,
    OP_AND_WORD_BIT,
    OP_AND_WORD_BIT_N,
    OP_OR_WORD_BIT,
    OP_OR_WORD_BIT_N,
    OP_MERGE_SERIES,
    OP_MERGE_PARALLEL,
    OP_OUT,
    OP_LOAD_IMM,
    OP_LOAD_IMM_N,
    OP_AND_IMM,
    OP_OR_IMM,
    OP_OUT_IMM,
    OP_CMP_EQ,
    OP_CMP_NE,
    OP_CMP_GE,
    OP_CMP_LT,
    OP_END
  } opcode_t;

  typedef struct packed {
    opcode_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [BITSEL_W-1:0] bit_sel;
    logic                use_ptr;
    logic [WORD_W-1:0]   cmp_b;
  } instr_t;

  typedef struct packed {
    logic              req;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic              wdata;
  } io_req_t;

  localparam logic [3:0] LEVEL_RESET = 4'h0;

endpackage : rung_pkg

// >>> verilog/boolean_rung_stack_evaluator.sv
/*
 * boolean_rung_stack_evaluator: executes one rung instruction per accepted
 * slot, holding the rung on an eight-level boolean stack.
 * assumes instruction, image, memory and physical i/o ports are synchronous
 * to CLK; memory and image reads are combinational, physical i/o answers
 * with PHY_ACK some cycles after PHY_REQ.
 */
// Summary of operation
// - open-contact load pushes the addressed point state unchanged.
// - closed-contact load pushes the inverse of the addressed point.
// - series join ANDs contact state into the current rung value.
// - parallel join ORs contact state into the current rung value.
// - joins after an output keep working on the current rung value.
// - intermediate results live in an eight-level boolean stack.
// - every load pushes on top; older entries move down a level.
// - series merge ANDs top two levels, parallel merge ORs them.
// - a rung needing more than eight levels is reported as error.
// - end-of-program stops execution; later instructions are ignored.
// - immediate access stalls execution until physical i/o completes.
// - immediate read uses fresh value once; image stays unchanged.
// - ordinary ops use image; each immediate op accesses i/o again.
// - immediate output drives the physical point and updates image.
// - word-bit contacts pick bit 0..15 directly or via pointer.
// - compare contacts give equal, not equal, ge or lt on bcd values.
`timescale 1ns/1ps
module boolean_rung_stack_evaluator
  import rung_pkg::*;
#(
  parameter int DEPTH = rung_pkg::STACK_DEPTH
) (
  input  wire logic                       CLK,
  input  wire logic                       ARST_N,
  input  wire logic                       CE,
  input  wire logic                       START,
  input  wire logic                       INSTR_VALID,
  input  wire rung_pkg::instr_t           INSTR,
  output logic                            INSTR_READY,
  input  wire logic                       IMAGE_BIT,
  input  wire logic [rung_pkg::WORD_W-1:0] MEM_WORD,
  input  wire logic [rung_pkg::WORD_W-1:0] PTR_WORD,
  output logic                            IMG_WE,
  output logic [rung_pkg::ADDR_W-1:0]     IMG_ADDR,
  output logic                            IMG_WDATA,
  output rung_pkg::io_req_t               PHY,
  input  wire logic                       PHY_ACK,
  input  wire logic                       PHY_RDATA,
  output logic                            RUNG_VALUE,
  output logic                            RUNNING,
  output logic                            OVERFLOW_ERR,
  output logic                            UNDERFLOW_ERR
);
  import rung_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_RUN, S_WAIT_IO, S_DONE} state_t;

  state_t             state_q, state_d;
  logic [DEPTH-1:0]   stack_q, stack_d;
  logic [3:0]         level_q, level_d;
  logic               ovf_q, unf_q;
  logic               instr_ready_q;
  logic               active_q;
  logic               img_we_q, img_wdata_q;
  logic [ADDR_W-1:0]  img_addr_q;
  io_req_t            phy_q;
  logic               imm_data_q;
  logic               imm_done;

  // bcd compare: digit-wise is same as binary for valid bcd
  function automatic logic word_bit(input logic [WORD_W-1:0] w,
                                    input logic [BITSEL_W-1:0] s);
    word_bit = w[s];
  endfunction : word_bit

  function automatic logic is_imm(input opcode_t o);
    is_imm = (o == OP_LOAD_IMM) || (o == OP_LOAD_IMM_N) ||
             (o == OP_AND_IMM) || (o == OP_OR_IMM) || (o == OP_OUT_IMM);
  endfunction : is_imm

  wire opcode_t op       = INSTR.op;
  wire          running  = (state_q == S_RUN);
  wire          take     = CE && running && INSTR_VALID && !is_imm(op);
  wire          imm_take = CE && running && INSTR_VALID && is_imm(op);
  wire [WORD_W-1:0] bw   = INSTR.use_ptr ? PTR_WORD : MEM_WORD;
  wire          wbit     = word_bit(bw, INSTR.bit_sel);
  wire          cmp_eq   = (MEM_WORD == INSTR.cmp_b);
  wire          cmp_ge   = (MEM_WORD >= INSTR.cmp_b);
  // fresh value used once, image not written on read
  wire          imm_val  = PHY_RDATA;
  wire          top      = stack_q[0];
  wire          second   = stack_q[1];

  assign imm_done = (state_q == S_WAIT_IO) && PHY_ACK;

  always_comb begin
    opcode_t     o;
    logic        c;
    logic        push;
    logic        ok;
    o        = phy_q.req ? OP_NOP : op;
    c        = 1'b0;
    push     = 1'b0;
    ok       = take || imm_done;
    stack_d  = stack_q;
    level_d  = level_q;
    if (imm_done) begin
      o = op;
    end
    case (o)
      OP_LOAD_OPEN:            begin c = IMAGE_BIT;  push = 1'b1; end
      OP_LOAD_CLOSED:          begin c = !IMAGE_BIT; push = 1'b1; end
      OP_LOAD_WORD_BIT_OPEN:   begin c = wbit;       push = 1'b1; end
      OP_LOAD_WORD_BIT_CLOSED: begin c = !wbit;      push = 1'b1; end
      OP_CMP_EQ:               begin c = cmp_eq;     push = 1'b1; end
      OP_CMP_NE:               begin c = !cmp_eq;    push = 1'b1; end
      OP_CMP_GE:               begin c = cmp_ge;     push = 1'b1; end
      OP_CMP_LT:               begin c = !cmp_ge;    push = 1'b1; end
      OP_LOAD_IMM:             begin c = imm_val;    push = 1'b1; end
      OP_LOAD_IMM_N:           begin c = !imm_val;   push = 1'b1; end
      default:                 begin c = 1'b0;       push = 1'b0; end
    endcase
    if (ok) begin
      if (push) begin
        stack_d = {stack_q[DEPTH-2:0], c};
        if (level_q < 4'(DEPTH)) begin
          level_d = level_q + 4'h1;
        end
      end
      case (o)
        OP_AND_OPEN:       stack_d[0] = top & IMAGE_BIT;
        OP_AND_CLOSED:     stack_d[0] = top & !IMAGE_BIT;
        OP_AND_WORD_BIT:   stack_d[0] = top & wbit;
        OP_AND_WORD_BIT_N: stack_d[0] = top & !wbit;
        OP_AND_IMM:        stack_d[0] = top & imm_val;
        OP_OR_OPEN:        stack_d[0] = top | IMAGE_BIT;
        OP_OR_CLOSED:      stack_d[0] = top | !IMAGE_BIT;
        OP_OR_WORD_BIT:    stack_d[0] = top | wbit;
        OP_OR_WORD_BIT_N:  stack_d[0] = top | !wbit;
        OP_OR_IMM:         stack_d[0] = top | imm_val;
        // merge two levels, skipped below two
        OP_MERGE_SERIES, OP_MERGE_PARALLEL: begin
          if (level_q >= 4'h2) begin
            stack_d = {1'b0, stack_q[DEPTH-1:1]};
            stack_d[0] = (o == OP_MERGE_SERIES) ? (top & second)
                                                : (top | second);
            level_d = level_q - 4'h1;
          end
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE:    if (START) state_d = S_RUN;
      S_RUN: begin
        if (imm_take) state_d = S_WAIT_IO;
        else if (take && op == OP_END) state_d = S_DONE;
      end
      S_WAIT_IO: if (PHY_ACK) state_d = S_RUN;
      S_DONE:    if (START) state_d = S_RUN;
      default:   state_d = S_IDLE;
    endcase
  end

  wire start_run = (state_q != S_RUN) && (state_d == S_RUN) &&
                   (state_q != S_WAIT_IO);
  wire out_now   = take && op == OP_OUT;
  wire out_imm   = imm_done && op == OP_OUT_IMM;
  function automatic logic push_op(input opcode_t o);
    push_op = o inside {OP_LOAD_OPEN, OP_LOAD_CLOSED, OP_LOAD_WORD_BIT_OPEN,
                        OP_LOAD_WORD_BIT_CLOSED, OP_CMP_EQ, OP_CMP_NE,
                        OP_CMP_GE, OP_CMP_LT, OP_LOAD_IMM, OP_LOAD_IMM_N};
  endfunction : push_op

  // push with all levels in use
  wire ovf_hit   = (take || imm_done) && (level_q == 4'(DEPTH)) &&
                   push_op(op);

  wire unf_hit = take && (op == OP_MERGE_SERIES || op == OP_MERGE_PARALLEL)
                 && (level_q < 4'h2);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q  <= S_IDLE;
      stack_q  <= '0;
      level_q  <= LEVEL_RESET;
      ovf_q    <= 1'b0;
      unf_q    <= 1'b0;
      active_q <= 1'b0;
    end else if (CE) begin
      state_q  <= state_d;
      stack_q  <= start_run ? '0 : stack_d;
      level_q  <= start_run ? LEVEL_RESET : level_d;
      ovf_q    <= start_run ? 1'b0 : (ovf_q | ovf_hit);
      unf_q    <= start_run ? 1'b0 : (unf_q | unf_hit);
      active_q <= (state_d == S_RUN) || (state_d == S_WAIT_IO);
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      phy_q       <= '0;
      img_we_q    <= 1'b0;
      img_addr_q  <= '0;
      img_wdata_q <= 1'b0;
    end else if (CE) begin
      // each immediate op issues a new physical access
      if (imm_take) begin
        phy_q.req   <= 1'b1;
        phy_q.we    <= (op == OP_OUT_IMM);
        phy_q.addr  <= INSTR.addr;
        phy_q.wdata <= top;
      end else if (PHY_ACK) begin
        phy_q.req   <= 1'b0;
      end
      img_we_q    <= out_now || out_imm;
      img_addr_q  <= INSTR.addr;
      img_wdata_q <= top;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      instr_ready_q <= 1'b0;
    end else if (CE) begin
      instr_ready_q <= (state_d == S_RUN) && !imm_take;
    end
  end

  assign INSTR_READY   = instr_ready_q;
  assign IMG_WE        = img_we_q;
  assign IMG_ADDR      = img_addr_q;
  assign IMG_WDATA     = img_wdata_q;
  assign PHY           = phy_q;
  assign RUNG_VALUE    = stack_q[0];
  assign RUNNING       = active_q;
  assign OVERFLOW_ERR  = ovf_q;
  assign UNDERFLOW_ERR = unf_q;

  // immediate access in two steps: request issued, then ack seen in wait
  sequence imm_issue;
    CE && imm_take;
  endsequence
  sequence imm_finish;
    CE && imm_done;
  endsequence

  chk_merge_series: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (take && op == OP_MERGE_SERIES && level_q >= 4'h2) |=>
    (stack_q[0] == ($past(stack_q[0]) & $past(stack_q[1]))))
    else $error("series merge wrong");
  chk_merge_parallel: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (take && op == OP_MERGE_PARALLEL && level_q >= 4'h2) |=>
    (stack_q[0] == ($past(stack_q[0]) | $past(stack_q[1]))))
    else $error("parallel merge wrong");
  chk_push_shift: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (take && op == OP_LOAD_OPEN) |=>
    (stack_q[DEPTH-1:1] == $past(stack_q[DEPTH-2:0])))
    else $error("push did not shift");
  chk_load_open: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (take && op == OP_LOAD_OPEN) |=> stack_q[0] == $past(IMAGE_BIT))
    else $error("open load wrong");
  chk_load_closed: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (take && op == OP_LOAD_CLOSED) |=> stack_q[0] != $past(IMAGE_BIT))
    else $error("closed load wrong");
  chk_end_halts: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (take && op == OP_END) |=> state_q == S_DONE && !RUNNING)
    else $error("end did not halt");
  // stack frozen while the physical access is pending
  chk_imm_stall: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && state_q == S_WAIT_IO && !PHY_ACK) |=> stack_q == $past(stack_q))
    else $error("ran during immediate access");
  // each immediate op raises a fresh physical request
  chk_imm_request: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    imm_issue |=> PHY.req && PHY.addr == $past(INSTR.addr))
    else $error("immediate op without request");
  // immediate read leaves the image alone
  chk_imm_read_image: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (imm_finish ##0 (op != OP_OUT_IMM)) |=> !IMG_WE)
    else $error("immediate read wrote image");
  chk_merge_underflow: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    unf_hit |=> UNDERFLOW_ERR && level_q == $past(level_q))
    else $error("underflow not flagged");
  chk_imm_out_image: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (imm_finish ##0 out_imm) |=>
    IMG_WE && IMG_WDATA == $past(PHY.wdata))
    else $error("immediate out no image write");
endmodule : boolean_rung_stack_evaluator

// >>> verification/rung_partner.sv
/* rung_partner: image register, data memory and physical i/o point model.
   assumes the bench presets img, mem and pin; acks DLY+1 cycles after req rises. */
`timescale 1ns/1ps
module rung_partner
  import rung_pkg::*;
#(
  parameter int DLY = 3
) (
  input  wire logic               CLK,
  input  wire rung_pkg::instr_t   INSTR,
  input  wire rung_pkg::io_req_t  PHY,
  input  wire logic               IMG_WE,
  input  wire logic [ADDR_W-1:0]  IMG_ADDR,
  input  wire logic               IMG_WDATA,
  output logic                    IMAGE_BIT,
  output logic [WORD_W-1:0]       MEM_WORD,
  output logic [WORD_W-1:0]       PTR_WORD,
  output logic                    PHY_ACK = 1'b0,
  output logic                    PHY_RDATA = 1'b0
);
  logic [15:0]       img = '0;
  logic [15:0]       pin = '0;
  logic [15:0]       pout = '0;
  logic [WORD_W-1:0] mem [16];
  int                cnt = 0;
  assign IMAGE_BIT = img[INSTR.addr[3:0]];
  assign MEM_WORD  = mem[INSTR.addr[3:0]];
  assign PTR_WORD  = mem[MEM_WORD[3:0]];
  // read data toggles outside the ack so a stale value is never trusted
  always @(posedge CLK) begin
    if (IMG_WE) img[IMG_ADDR[3:0]] <= IMG_WDATA;
    PHY_ACK <= 1'b0;
    PHY_RDATA <= ~PHY_RDATA;
    if (PHY.req && cnt == 0 && !PHY_ACK) cnt <= DLY;
    if (cnt > 0) cnt <= cnt - 1;
    if (cnt == 1) begin
      PHY_ACK <= 1'b1;
      PHY_RDATA <= pin[PHY.addr[3:0]];
      if (PHY.we) pout[PHY.addr[3:0]] <= PHY.wdata;
    end
  end
endmodule : rung_partner

// >>> verification/boolean_rung_stack_evaluator_tb.sv
/* boolean_rung_stack_evaluator_tb: self-checking scenarios for the rung
   evaluator; assumes rung_partner serves image, memory and physical i/o. */
`timescale 1ns/1ps
module boolean_rung_stack_evaluator_tb;
  import rung_pkg::*;
  logic              CLK = 1'b0;
  logic              ARST_N = 1'b0;
  logic              CE = 1'b1;
  logic              START = 1'b0;
  logic              INSTR_VALID = 1'b0;
  instr_t            INSTR = '0;
  io_req_t           PHY;
  logic [WORD_W-1:0] MEM_WORD, PTR_WORD;
  logic [ADDR_W-1:0] IMG_ADDR;
  logic              INSTR_READY, IMAGE_BIT, IMG_WE, IMG_WDATA, PHY_ACK;
  logic              PHY_RDATA, RUNG_VALUE, RUNNING, OVERFLOW_ERR;
  logic              UNDERFLOW_ERR;
  int                err_total = 0;
  int                check_count = 0;

  boolean_rung_stack_evaluator DUT (
    .CLK           (CLK),
    .ARST_N        (ARST_N),
    .CE            (CE),
    .START         (START),
    .INSTR_VALID   (INSTR_VALID),
    .INSTR         (INSTR),
    .INSTR_READY   (INSTR_READY),
    .IMAGE_BIT     (IMAGE_BIT),
    .MEM_WORD      (MEM_WORD),
    .PTR_WORD      (PTR_WORD),
    .IMG_WE        (IMG_WE),
    .IMG_ADDR      (IMG_ADDR),
    .IMG_WDATA     (IMG_WDATA),
    .PHY           (PHY),
    .PHY_ACK       (PHY_ACK),
    .PHY_RDATA     (PHY_RDATA),
    .RUNG_VALUE    (RUNG_VALUE),
    .RUNNING       (RUNNING),
    .OVERFLOW_ERR  (OVERFLOW_ERR),
    .UNDERFLOW_ERR (UNDERFLOW_ERR)
  );
  rung_partner u_part (
    .CLK       (CLK),
    .INSTR     (INSTR),
    .PHY       (PHY),
    .IMG_WE    (IMG_WE),
    .IMG_ADDR  (IMG_ADDR),
    .IMG_WDATA (IMG_WDATA),
    .IMAGE_BIT (IMAGE_BIT),
    .MEM_WORD  (MEM_WORD),
    .PTR_WORD  (PTR_WORD),
    .PHY_ACK   (PHY_ACK),
    .PHY_RDATA (PHY_RDATA)
  );

  initial forever #25 CLK = ~CLK;

  task automatic chk(string nm, logic s, logic e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", nm, e, s);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // immediate ops hold the request through the edge that sees the ack
  task automatic go(opcode_t op, int a, int b = 0, bit p = 0, int c = 0);
    int n;
    n = 0;
    INSTR = '{op, a[ADDR_W-1:0], b[BITSEL_W-1:0], p, c[WORD_W-1:0]};
    INSTR_VALID = 1'b1;
    @(posedge CLK);
    #1;
    if (op inside {[OP_LOAD_IMM:OP_OUT_IMM]}) begin
      while (PHY_ACK !== 1'b1) begin
        @(posedge CLK);
        #1;
        n++;
        if (n > 50) begin
          err_total++;
          complete_run();
        end
      end
      @(posedge CLK);
      #1;
    end
  endtask : go

  task automatic step(opcode_t op, int a, logic e, int b = 0, bit p = 0,
                      int c = 0);
    go(op, a, b, p, c);
    chk(op.name(), RUNG_VALUE, e);
  endtask : step

  task automatic begin_scan;
    INSTR_VALID = 1'b0;
    START = 1'b1;
    @(posedge CLK);
    #1;
    START = 1'b0;
  endtask : begin_scan

  task automatic s_basic;
    u_part.img = 16'h0082;
    begin_scan();
    step(OP_LOAD_OPEN, 1, 1'b1);
    step(OP_LOAD_CLOSED, 1, 1'b0);
    step(OP_OR_OPEN, 1, 1'b1);
    step(OP_AND_OPEN, 0, 1'b0);
    step(OP_OR_CLOSED, 0, 1'b1);
    step(OP_AND_CLOSED, 1, 1'b0);
    step(OP_OR_OPEN, 1, 1'b1);
    go(OP_OUT, 6);
    step(OP_AND_OPEN, 0, 1'b0);
    go(OP_OUT, 7);
    go(OP_END, 0);
    chk("img6", u_part.img[6], 1'b1);
    chk("img7", u_part.img[7], 1'b0);
  endtask : s_basic

  task automatic s_stack;
    logic [7:0] p = 8'hA6;
    u_part.img = {8'h00, p};
    begin_scan();
    for (int k = 0; k < 8; k++)
      step(OP_LOAD_OPEN, k, p[k]);
    chk("ovf8", OVERFLOW_ERR, 1'b0);
    step(OP_MERGE_SERIES, 0, p[7] & p[6]);
    step(OP_MERGE_PARALLEL, 0, (p[7] & p[6]) | p[5]);
    for (int k = 0; k < 3; k++)
      step(OP_LOAD_OPEN, k, p[k]);
    chk("ovf9", OVERFLOW_ERR, 1'b1);
    go(OP_END, 0);
  endtask : s_stack

  task automatic s_under;
    begin_scan();
    chk("ovf_clr", OVERFLOW_ERR, 1'b0);
    step(OP_LOAD_OPEN, 1, 1'b1);
    step(OP_MERGE_SERIES, 0, 1'b1);
    chk("unf", UNDERFLOW_ERR, 1'b1);
    go(OP_END, 0);
  endtask : s_under

  task automatic s_imm;
    u_part.img = 16'h0000;
    u_part.pin = 16'h0004;
    begin_scan();
    step(OP_LOAD_IMM, 2, 1'b1);
    chk("img2", u_part.img[2], 1'b0);
    step(OP_LOAD_OPEN, 2, 1'b0);
    u_part.pin = 16'h0000;
    step(OP_OR_IMM, 2, 1'b0);
    step(OP_LOAD_IMM_N, 2, 1'b1);
    u_part.pin = 16'h0004;
    step(OP_AND_IMM, 2, 1'b1);
    go(OP_OUT_IMM, 5);
    chk("pout5", u_part.pout[5], 1'b1);
    go(OP_END, 0);
    chk("img5", u_part.img[5], 1'b1);
  endtask : s_imm

  task automatic s_word;
    u_part.mem[3] = 16'h8001;
    u_part.mem[4] = 16'h0009;
    u_part.mem[9] = 16'h0020;
    begin_scan();
    step(OP_LOAD_WORD_BIT_OPEN, 3, 1'b1, 15);
    step(OP_LOAD_WORD_BIT_OPEN, 3, 1'b0, 14);
    step(OP_LOAD_WORD_BIT_CLOSED, 3, 1'b0, 0);
    step(OP_OR_WORD_BIT, 3, 1'b1, 0);
    step(OP_AND_WORD_BIT_N, 3, 1'b0, 15);
    step(OP_OR_WORD_BIT_N, 3, 1'b1, 1);
    step(OP_AND_WORD_BIT, 3, 1'b0, 14);
    step(OP_LOAD_WORD_BIT_OPEN, 4, 1'b1, 5, 1'b1);
    go(OP_END, 0);
  endtask : s_word

  // compare contacts, each after a true load
  task automatic s_cmp;
    opcode_t    ops [6] = '{OP_CMP_EQ, OP_CMP_NE, OP_CMP_GE, OP_CMP_LT,
                            OP_CMP_GE, OP_CMP_LT};
    logic [5:0] ex = 6'h25;
    logic [WORD_W-1:0] lim [2] = '{16'h0025, 16'h0026};
    u_part.img = 16'h0002;
    u_part.mem[4] = 16'h0025;
    begin_scan();
    for (int i = 0; i < 6; i++) begin
      step(OP_LOAD_OPEN, 1, 1'b1);
      step(ops[i], 4, ex[i], 0, 1'b0, lim[i / 4]);
    end
    go(OP_END, 0);
  endtask : s_cmp

  // nothing runs after end; CE low freezes the evaluator
  task automatic s_end;
    begin_scan();
    step(OP_LOAD_OPEN, 1, 1'b1);
    chk("running_on", RUNNING, 1'b1);
    chk("ready_on", INSTR_READY, 1'b1);
    CE = 1'b0;
    go(OP_LOAD_CLOSED, 1);
    chk("ce_hold", RUNG_VALUE, 1'b1);
    CE = 1'b1;
    step(OP_LOAD_CLOSED, 1, 1'b0);
    go(OP_END, 0);
    chk("running", RUNNING, 1'b0);
    chk("ready_off", INSTR_READY, 1'b0);
    step(OP_LOAD_OPEN, 1, 1'b0);
  endtask : s_end

  initial begin
    repeat (4) @(posedge CLK);
    #1;
    ARST_N = 1'b1;
    s_basic();
    s_stack();
    s_under();
    s_imm();
    s_word();
    s_cmp();
    s_end();
    complete_run();
  end
endmodule : boolean_rung_stack_evaluator_tb
